// File: design/fgar_top.sv
/*
 * Fast address gate and alternate CPU reset register, plus the three
 * keyboard-controller port output drivers.
 * Assumes host bus strobes, config bits and controller signals are
 * synchronous to i_ref_clk; CPU reset input is a pin and is synchronised.
 */
`timescale 1ns/1ps
// Functional notes
// - Register access only when config enable set
// - Bit0 set: wait 14us, pulse low 6us
// - New pulse only after bit0 cleared
// - Reset clears bit0, reset output high
// - Combined reset is AND, polarity configurable
// - Bit1 drives alternate gate level
// - Line20 mask is OR of gates
// - Reset drives alternate gate low
// - Controller port bit is software gate
// - Port value zero drives pin low
// - Rising value drives high briefly, then releases
// - Open drain never drives high
// - Controller mode ignores input/invert config
module fgar_top
    import fgar_pkg::*;
#(
    parameter int DELAY_CYC = FGAR_DELAY_CYC,
    parameter int PULSE_CYC = FGAR_PULSE_CYC
) (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_arst_n,
    // Host I/O bus
    input  wire fgar_bus_t  i_bus,
    output logic [7:0]      o_rdata,
    output logic            o_rvalid,
    // Configuration
    input  wire logic [7:0] i_kbd_reset_gate_cfg,
    input  wire logic       i_reset_polarity_inv,
    input  wire logic       i_open_drain,
    input  wire logic       i_gp_as_input,
    input  wire logic       i_gp_invert,
    // Keyboard controller side
    input  wire logic       i_kbc_cpu_reset_n,
    input  wire logic       i_kbc_gate_port_bit,
    input  wire logic       i_cpu_reset_in,
    input  wire logic [2:0] i_kbc_out,
    // Outputs
    output logic            o_combined_reset_out,
    output logic            o_alternate_cpu_reset_n,
    output logic            o_alternate_addr_gate,
    output logic            o_cpu_line20_mask_n,
    output fgar_pin_t [2:0] o_kbc_pin
);
    // Register and sequencer state
    logic                  rst_bit_q;   // Bit 0 of the register
    logic                  gate_bit_q;  // Bit 1 of the register
    logic                  armed_q;     // Pulse allowed for this bit-0 setting
    fgar_rst_st_t          st_q;        // Sequencer state
    logic [FGAR_CNT_W-1:0] cnt_q;       // Sequencer counter
    logic                  cpu_reset_in_s1_q; // Synchroniser first stage
    logic                  cpu_reset_in_s2_q; // Synchroniser second stage
    logic                  en;          // Register enabled
    logic                  hit_wr;      // Enabled write
    logic                  hit_rd;      // Enabled read
    logic                  alt_low;     // Alternate reset active

    // Address decode used for both reads and writes
    function automatic logic fgar_hit(input logic [15:0] a);
        return a == FGAR_REG_ADDR;
    endfunction

    assign en     = i_kbd_reset_gate_cfg[FGAR_CFG_EN_BIT];
    assign hit_wr = i_bus.wr && en && fgar_hit(i_bus.addr);
    assign hit_rd = i_bus.rd && en && fgar_hit(i_bus.addr);
    assign alt_low = (st_q == FGAR_PULSE);

    // CPU reset pin synchroniser
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cpu_reset_in_s1_q <= 1'b0;
            cpu_reset_in_s2_q <= 1'b0;
        end else begin
            cpu_reset_in_s1_q <= i_cpu_reset_in;
            cpu_reset_in_s2_q <= cpu_reset_in_s1_q;
        end
    end

    // Register bits 0 and 1
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_bit_q  <= 1'b0;
            gate_bit_q <= 1'b0;
        end else if (hit_wr) begin
            rst_bit_q  <= i_bus.wdata[FGAR_BIT_RST];
            gate_bit_q <= i_bus.wdata[FGAR_BIT_GATE];
        end
    end

    // Read data; reserved bits fixed
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata  <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= hit_rd;
            if (hit_rd) begin
                o_rdata <= FGAR_RD_FIXED_ONES |
                           {6'h00, gate_bit_q, rst_bit_q};
            end
        end
    end

    // Re-arm only once bit 0 has gone back to zero
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            armed_q <= 1'b1;
        end else if (!rst_bit_q) begin
            armed_q <= 1'b1;
        end else if (st_q == FGAR_WAIT) begin
            armed_q <= 1'b0;
        end
    end

    // Delay then low pulse sequencer
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q  <= FGAR_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (st_q)
                FGAR_IDLE: begin
                    // Start on a set bit that has not pulsed yet
                    if (rst_bit_q && armed_q) begin
                        st_q  <= FGAR_WAIT;
                        cnt_q <= FGAR_CNT_W'(DELAY_CYC - 1);
                    end
                end
                FGAR_WAIT: begin
                    // Count the lead-in delay
                    if (cnt_q == '0) begin
                        st_q  <= FGAR_PULSE;
                        cnt_q <= FGAR_CNT_W'(PULSE_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                FGAR_PULSE: begin
                    // Hold the output low
                    if (cnt_q == '0) begin
                        st_q <= FGAR_DONE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                FGAR_DONE: begin
                    // Wait for bit 0 to clear
                    if (!rst_bit_q) begin
                        st_q <= FGAR_IDLE;
                    end
                end
            endcase
        end
    end

    // Reset and gate outputs
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_alternate_cpu_reset_n <= 1'b1;
            o_alternate_addr_gate   <= 1'b0;
            o_cpu_line20_mask_n     <= 1'b0;
            o_combined_reset_out    <= 1'b1;
        end else begin
            o_alternate_cpu_reset_n <= !alt_low;
            o_alternate_addr_gate   <= gate_bit_q;
            // Controller port bit acts as software gate, CPU reset also forces it
            o_cpu_line20_mask_n <= i_kbc_gate_port_bit | gate_bit_q | cpu_reset_in_s2_q;
            // AND the active-low pulses, then apply pin polarity
            o_combined_reset_out <= (i_kbc_cpu_reset_n & (!(en && alt_low)))
                                    ^ i_reset_polarity_inv;
        end
    end

    // Port drivers; input and invert settings are not wired in
    generate
        for (genvar g = 0; g < 3; g++) begin : g_port
            fgar_port_drv u_drv (
                .i_ref_clk    (i_ref_clk),
                .i_arst_n     (i_arst_n),
                .i_val        (i_kbc_out[g]),
                .i_open_drain (i_open_drain),
                .o_pin        (o_kbc_pin[g])
            );
        end
    endgenerate

    // Unused config kept visible for reviewers
    logic unused_cfg;
    assign unused_cfg = i_gp_as_input ^ i_gp_invert;

    // Disabled register never answers
    no_access_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        !en |=> !o_rvalid) else $error("access while disabled");
    // Fixed bits on readback
    rd_fixed_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        o_rvalid |-> (o_rdata & 8'hFC) == FGAR_RD_FIXED_ONES) else $error("reserved bits wrong");
    // Pulse starts after the delay
    delay_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        $rose(st_q == FGAR_WAIT) |-> (st_q == FGAR_WAIT)[*8]) else $error("pulse too early");
    // Pulse width held
    pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        $fell(o_alternate_cpu_reset_n) |-> !o_alternate_cpu_reset_n[*8]) else $error("pulse too short");
    // No second pulse while bit stays set
    rearm_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        st_q == FGAR_DONE && rst_bit_q |=> st_q == FGAR_DONE) else $error("re-pulse without clear");
    // Gate output follows bit 1
    gate_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        hit_wr |=> ##1 o_alternate_addr_gate == $past(i_bus.wdata[FGAR_BIT_GATE], 2))
        else $error("gate not following write");
    // Mask high when alternate gate high
    mask_or_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        gate_bit_q |=> o_cpu_line20_mask_n) else $error("mask not high");
    // Combined reset asserted with controller reset
    comb_rst_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        !i_kbc_cpu_reset_n |=> o_combined_reset_out == $past(i_reset_polarity_inv))
        else $error("combined reset wrong");
endmodule

// File: design/fgar_pkg.sv
/*
 * Package for the fast address gate / alternate reset block.
 * Assumes a single 100 MHz reference clock and an 8-bit host I/O bus.
 */
package fgar_pkg;
    // Register location and layout
    localparam logic [15:0] FGAR_REG_ADDR      = 16'h0092;  // Fast gate register I/O address
    localparam logic [7:0]  FGAR_REG_RESET     = 8'h24;     // Reset value as read back
    localparam logic [7:0]  FGAR_RD_FIXED_ONES = 8'h24;     // Bits 5 and 2 read as one
    localparam int          FGAR_BIT_RST       = 0;         // Alternate reset request bit
    localparam int          FGAR_BIT_GATE      = 1;         // Alternate address gate bit
    localparam int          FGAR_CFG_EN_BIT    = 2;         // Enable bit in gate config register
    // Timing, in nanoseconds, and derived clock counts
    localparam int          FGAR_CLK_NS        = 10;        // Reference clock period
    localparam int          FGAR_DELAY_NS      = 14000;     // Least delay before the pulse
    localparam int          FGAR_PULSE_NS      = 6000;      // Least pulse width
    localparam int          FGAR_DRIVE_NS      = 500;       // Active high drive time
    localparam int          FGAR_DELAY_CYC     = (FGAR_DELAY_NS + FGAR_CLK_NS - 1) / FGAR_CLK_NS;
    localparam int          FGAR_PULSE_CYC     = (FGAR_PULSE_NS + FGAR_CLK_NS - 1) / FGAR_CLK_NS;
    localparam int          FGAR_DRIVE_CYC     = (FGAR_DRIVE_NS + FGAR_CLK_NS - 1) / FGAR_CLK_NS;
    localparam int          FGAR_CNT_W         = 11;        // Wide enough for the longest count

    // Alternate reset sequencer states, Gray along the path
    typedef enum logic [1:0] {
        FGAR_IDLE  = 2'b00,
        FGAR_WAIT  = 2'b01,
        FGAR_PULSE = 2'b11,
        FGAR_DONE  = 2'b10
    } fgar_rst_st_t;

    // One port pin as level and enable
    typedef struct packed {
        logic o;   // Driven level
        logic oe;  // High while driving
    } fgar_pin_t;

    // Host bus access
    typedef struct packed {
        logic [15:0] addr;  // I/O address
        logic [7:0]  wdata; // Write data
        logic        wr;    // Write strobe, one cycle
        logic        rd;    // Read strobe, one cycle
    } fgar_bus_t;
endpackage

// File: design/fgar_port_drv.sv
/*
 * One keyboard-controller port output driver.
 * Assumes port value is synchronous to i_ref_clk.
 */
`timescale 1ns/1ps
module fgar_port_drv
    import fgar_pkg::*;
#(
    parameter int DRIVE_CYC = FGAR_DRIVE_CYC
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_arst_n,
    // Control
    input  wire logic i_val,
    input  wire logic i_open_drain,
    // Pin
    output fgar_pin_t o_pin
);
    logic [FGAR_CNT_W-1:0] cnt_q;  // Remaining drive-high cycles
    logic                  val_q;  // Previous port value

    // Track edges and count the boost window
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            val_q <= 1'b1;
            cnt_q <= '0;
        end else begin
            val_q <= i_val;
            if (i_val && !val_q && !i_open_drain) begin
                cnt_q <= FGAR_CNT_W'(DRIVE_CYC);
            end else if (!i_val || i_open_drain) begin
                cnt_q <= '0;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Low drives, high drives only during the window, then released
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pin <= '0;
        end else begin
            o_pin.o  <= i_val;
            // Window term gated too: a switch to open drain mid-window must not drive high
            o_pin.oe <= !i_val ||
                        (i_val && !val_q && !i_open_drain) ||
                        (!i_open_drain && cnt_q > FGAR_CNT_W'(1));
        end
    end

    // Never drives high in open-drain mode
    od_no_high_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        $past(i_open_drain) && $past(i_val) |-> !o_pin.oe) else $error("open drain drove high");
    // Zero drives low next cycle
    zero_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        !i_val |=> o_pin.oe && !o_pin.o) else $error("zero not driven low");
endmodule

// File: verif/fgar_host_mdl.sv
/*
 * Host model: issues one-cycle I/O write and read strobes on the gate bus.
 * Assumes one bench process calls its tasks, starting just after a clock edge.
 */
`timescale 1ns/1ps
module fgar_host_mdl
    import fgar_pkg::*;
(
    // Clock and read answer
    input  wire logic       i_ref_clk,
    input  wire logic       i_rvalid,
    input  wire logic [7:0] i_rdata,
    // Bus toward the device
    output fgar_bus_t       o_bus
);
    // Idle bus from time zero
    initial o_bus = '0;

    // One write strobe; released bus shows inverted values, not the old ones
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk);
        o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // One read strobe; answer awaited for a bounded four cycles
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge i_ref_clk);
        o_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk);
        o_bus <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        repeat (4) begin
            #1;
            if (!ok && i_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = i_rdata;
            end
            @(posedge i_ref_clk);
        end
    endtask

    // Clearing the request bit re-arms the reset pulse
    task automatic rearm();
        io_wr(FGAR_REG_ADDR, 8'h00);
    endtask
endmodule

// File: verif/tb.sv
/*
 * Self-checking bench for the fast gate / alternate reset block.
 * Assumes the host model on the bus and pull-ups on all three port pins.
 */
`timescale 1ns/1ps
module tb
    import fgar_pkg::*;
();
    localparam int DLY = 10;  // Shortened delay count
    localparam int PLS = 9;   // Shortened pulse count
    // Bench signals
    logic            clk, rst_n, rvalid, pol, od, gpin, gpinv, kbcrst, gport, cpu_reset_in;
    logic            comb, altn, gate, mask, ok;
    logic [7:0]      rdata, cfg, w, r;
    logic [2:0]      kout;
    fgar_bus_t       bus;
    fgar_pin_t [2:0] pin;
    int              error_cnt, samples_checked, i, k;
    integer          seed = 32'h5036AE1B;

    fgar_host_mdl host (.i_ref_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_bus(bus));
    fgar_top #(.DELAY_CYC(DLY), .PULSE_CYC(PLS)) uut (
        .i_ref_clk(clk), .i_arst_n(rst_n), .i_bus(bus), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_kbd_reset_gate_cfg(cfg), .i_reset_polarity_inv(pol), .i_open_drain(od),
        .i_gp_as_input(gpin), .i_gp_invert(gpinv), .i_kbc_cpu_reset_n(kbcrst),
        .i_kbc_gate_port_bit(gport), .i_cpu_reset_in(cpu_reset_in), .i_kbc_out(kout),
        .o_combined_reset_out(comb), .o_alternate_cpu_reset_n(altn), .o_alternate_addr_gate(gate),
        .o_cpu_line20_mask_n(mask), .o_kbc_pin(pin));

    // 100 MHz clock
    always #5 clk = ~clk;

    // Expected read value: fixed ones plus the two live bits
    function automatic logic [7:0] exp_rd(input logic [7:0] v);
        return FGAR_RD_FIXED_ONES | (v & 8'h03);
    endfunction
    // Expected combined reset level
    function automatic logic exp_comb(input logic kn, input logic p, input logic inv);
        return (kn & ~p) ^ inv;
    endfunction
    // Pin level with pull-up when released
    function automatic logic lvl(input fgar_pin_t p);
        return p.oe ? p.o : 1'b1;
    endfunction

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Reset for 20 cycles, then idle outputs
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("rst_alt", 1'b1, altn);
        chk("rst_gate", 1'b0, gate);
        chk("rst_oe", 3'b000, {pin[2].oe, pin[1].oe, pin[0].oe});
    endtask

    // Request a pulse; measure its delay and width over a fixed window
    task automatic pulse_chk(input logic want);
        int lo, t;
        lo = 0;
        host.io_wr(FGAR_REG_ADDR, 8'h01);
        for (t = 0; t < 80; t++) begin
            @(posedge clk);
            #1;
            if (altn === 1'b0) begin
                if (lo == 0) chk("delay", 1'b1, t >= DLY - 1 && t <= DLY + 4);
                lo++;
                if (lo == 3) chk("comb_pulse", exp_comb(kbcrst, 1'b1, pol), comb);
            end
        end
        chk("pulse_len", 1'b1, want ? (lo >= PLS && lo <= PLS + 1) : lo == 0);
    endtask

    // One port pin: low, then rise with brief drive or open drain
    task automatic port_chk(input int n, input logic odv);
        int t, drv;
        drv = 0;
        @(posedge clk);
        od    <= odv;
        gpin  <= 1'($random(seed));
        gpinv <= 1'($random(seed));
        kout[n] <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("pin_low", 2'b10, {pin[n].oe, lvl(pin[n])});
        @(posedge clk);
        kout[n] <= 1'b1;
        for (t = 0; t < FGAR_DRIVE_CYC + 10; t++) begin
            @(posedge clk);
            #1;
            if (pin[n].oe === 1'b1) drv++;
            if (pin[n].oe === 1'b1) chk("pin_hi", 1'b1, pin[n].o);
        end
        chk("drive_len", 1'b1, odv ? drv == 0 : (drv >= FGAR_DRIVE_CYC - 2 && drv <= FGAR_DRIVE_CYC + 2));
        chk("pin_rel", 2'b01, {pin[n].oe, lvl(pin[n])});
    endtask

    // Bound on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    // Main sequence
    initial begin
        {clk, rst_n, pol, od, gpin, gpinv, gport, cpu_reset_in, kout} = '0;
        kbcrst = 1'b1;
        cfg = 8'h04;
        do_reset();
        host.io_rd(FGAR_REG_ADDR, r, ok);
        chk("rd_reset", FGAR_REG_RESET, r);
        $display("test reset done");
        for (i = 0; i < 20; i++) begin
            w = 8'($random(seed)) & 8'hFE;
            host.io_wr(FGAR_REG_ADDR, w);
            host.io_rd(FGAR_REG_ADDR, r, ok);
            chk("rd_ok", 1'b1, ok);
            chk("rd_val", exp_rd(w), r);
            gport  <= 1'($random(seed));
            cpu_reset_in <= 1'($random(seed));
            kbcrst <= 1'($random(seed));
            pol    <= 1'($random(seed));
            repeat (4) @(posedge clk);
            #1;
            chk("alt_gate", w[1], gate);
            chk("mask", w[1] | gport | cpu_reset_in, mask);
            chk("comb_idle", exp_comb(kbcrst, 1'b0, pol), comb);
        end
        $display("test register done");
        host.io_wr(FGAR_REG_ADDR, 8'h00);
        @(posedge clk);
        cfg <= 8'($random(seed)) & 8'hFB;
        host.io_wr(FGAR_REG_ADDR, 8'h02);
        host.io_rd(FGAR_REG_ADDR, r, ok);
        chk("rd_off", 1'b0, ok);
        cfg <= 8'h04;
        host.io_wr(16'h0093, 8'h02);
        host.io_rd(16'h0093, r, ok);
        chk("rd_addr", 1'b0, ok);
        #1;
        chk("gate_off", 1'b0, gate);
        $display("test refusal done");
        pulse_chk(1'b1);
        pulse_chk(1'b0);
        host.rearm();
        pulse_chk(1'b1);
        host.io_wr(FGAR_REG_ADDR, 8'h00);
        host.io_wr(FGAR_REG_ADDR, 8'h01);
        repeat (DLY + 4) @(posedge clk);
        do_reset();
        host.io_rd(FGAR_REG_ADDR, r, ok);
        chk("rd_after_rst", FGAR_REG_RESET, r);
        pulse_chk(1'b1);
        $display("test pulse done");
        for (k = 0; k < 6; k++) port_chk(k % 3, k / 3);
        $display("test ports done");
        summarize();
    end
endmodule
